// ===== include/gdr_pkg.sv
/*
  gdr_pkg: offsets, field positions, reset value, timing constants and
  carrier structs for the gate driver one timing/current register.
  assumes: included before any rtl file that refers to gdr_pkg::.
*/
package gdr_pkg;

  // register map
  localparam logic [7:0]  GD1_TC_OFFSET = 8'h04;
  localparam logic [15:0] GD1_TC_RESET  = 16'h0000;

  // field positions
  localparam int CHG_MSB = 15;
  localparam int CHG_LSB = 11;
  localparam int DT_MSB  = 10;
  localparam int DT_LSB  = 7;
  localparam int RES_BIT = 6;
  localparam int DIS_MSB = 5;
  localparam int DIS_LSB = 1;
  localparam int PAR_BIT = 0;

  // writable bit mask: reserved bit 6 never stored
  localparam logic [15:0] GD1_TC_WMASK = 16'hFFBF;

  // current scale: code n gives n * max_gate_current / 31
  localparam int CUR_FULL_SCALE = 31;

  // dead time per step and clock
  localparam int DT_STEP_NS    = 250;
  localparam int DT_MAX_NS     = 4000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DT_STEP_CYC   = DT_STEP_NS / CLK_PERIOD_NS;
  localparam int DT_MAX_CYC    = DT_MAX_NS / CLK_PERIOD_NS;

  // register write request from the serial interface
  typedef struct packed {
    logic        wr_en;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } gdr_req_s;

  // settings delivered to one gate-driver leg
  typedef struct packed {
    logic [4:0]  charge_current_code;
    logic        charge_lowz;
    logic [4:0]  discharge_current_code;
    logic        discharge_lowz;
    logic [3:0]  dead_time_code;
    logic [8:0]  dead_time_cycles;
  } gdr_leg_cfg_s;

endpackage

// ===== rtl/gdr_field_decode.sv
/*
  gdr_field_decode: turns the stored register word into the settings
  of one gate-driver leg.
  assumes: word is a registered value on the same clock.
*/
`timescale 1ns/10ps
module gdr_field_decode (
  input  wire logic [15:0]          word,
  output gdr_pkg::gdr_leg_cfg_s     cfg
);

  logic [4:0] chg;
  logic [4:0] dis;
  logic [3:0] dtc;

  // field extraction and derived settings
  always_comb begin
    chg = word[gdr_pkg::CHG_MSB:gdr_pkg::CHG_LSB];
    dis = word[gdr_pkg::DIS_MSB:gdr_pkg::DIS_LSB];
    dtc = word[gdr_pkg::DT_MSB:gdr_pkg::DT_LSB];
    cfg.charge_current_code    = chg;
    cfg.charge_lowz            = (chg == 5'h0);
    cfg.discharge_current_code = dis;
    cfg.discharge_lowz         = (dis == 5'h0);
    cfg.dead_time_code         = dtc;
    // (k+1) steps of the dead-time unit, 25 to 400 cycles
    cfg.dead_time_cycles = 9'((32'(dtc) + 1) * gdr_pkg::DT_STEP_CYC);
  end

endmodule

// ===== rtl/gdr_timing_current_reg.sv
/*
  gdr_timing_current_reg: gate driver one timing/current register,
  with field decode and routing to full bridge or leg 1.
  assumes: serial interface delivers decoded one-cycle write strobes and
  a read address on clk; input_mode_select comes from logic on clk.
*/
`timescale 1ns/10ps
// Summary of operation
// - 16-bit register at offset 0x04, resets to all zeros.
// - bits 15:11 charge code n, current n times max over 31.
// - charge code zero selects low-impedance charging switches.
// - bits 10:7 dead-time code k gives (k+1) times 250 ns.
// - bits 5:1 discharge code n, current n times max over 31.
// - discharge code zero selects low-impedance discharge switches.
// - input mode 0 applies fields to full bridge, 1 to leg 1.
// - bit 0 carries parity; bit 6 reserved, reads zero.
module gdr_timing_current_reg (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire gdr_pkg::gdr_req_s     req,
  input  wire logic [7:0]            rd_addr,
  input  wire logic                  input_mode_select,
  output logic [15:0]                rd_data,
  output logic                       rd_hit,
  output gdr_pkg::gdr_leg_cfg_s      bridge_cfg,
  output logic                       bridge_active,
  output logic                       leg_one_active,
  output logic [7:0]                 max_gate_scale
);

  logic [15:0]           word;
  logic [15:0]           next_word;
  gdr_pkg::gdr_leg_cfg_s dec_cfg;
  gdr_pkg::gdr_leg_cfg_s next_bridge_cfg;
  logic                  next_bridge_active;
  logic                  next_leg_one_active;

  function automatic logic hit(input logic [7:0] a);
    hit = (a == gdr_pkg::GD1_TC_OFFSET);
  endfunction

  // next register value on a write to this offset
  always_comb begin
    next_word = word;
    if (req.wr_en && hit(req.addr)) begin
      next_word = req.wdata & gdr_pkg::GD1_TC_WMASK;
    end
  end

  // register state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word <= gdr_pkg::GD1_TC_RESET;
    end else begin
      word <= next_word;
    end
  end

  // read port: parity bit stored as written, reserved bit zero
  always_comb begin
    rd_hit  = hit(rd_addr);
    rd_data = rd_hit ? word : 16'h0000;
  end

  gdr_field_decode u_decode (
    .word (word),
    .cfg  (dec_cfg)
  );

  // routing: full bridge or leg 1 only
  always_comb begin
    next_bridge_cfg     = dec_cfg;
    next_bridge_active  = (input_mode_select == 1'b0);
    next_leg_one_active = (input_mode_select == 1'b1);
  end

  // registered data outputs for the analog side
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bridge_cfg     <= '0;
      bridge_active  <= 1'b0;
      leg_one_active <= 1'b0;
    end else begin
      bridge_cfg     <= next_bridge_cfg;
      bridge_active  <= next_bridge_active;
      leg_one_active <= next_leg_one_active;
    end
  end

  // current full-scale divisor
  assign max_gate_scale = 8'(gdr_pkg::CUR_FULL_SCALE);

  // checks: the release edge still runs the reset branch, so every
  // check that looks one edge ahead needs rst_b in its antecedent

  // write accepted while out of reset
  sequence wr_hit_s;
    rst_b && req.wr_en && hit(req.addr);
  endsequence

  // no write to this register in this cycle
  sequence wr_idle_s;
    rst_b && !(req.wr_en && hit(req.addr));
  endsequence

  // write accepted, then one edge for the word to settle
  sequence wr_land_s;
    wr_hit_s ##1 1'b1;
  endsequence

  // two sampled edges out of reset, registered outputs left reset
  sequence run_s;
    rst_b && $past(rst_b);
  endsequence

  // a write stores the masked word
  property wr_store_p;
    @(posedge clk) disable iff (!rst_b)
      wr_hit_s |=>
        (word == ($past(req.wdata) & gdr_pkg::GD1_TC_WMASK));
  endproperty
  wr_store_a: assert property (wr_store_p)
    else $error("write not stored");

  // without a write the word holds
  word_hold_a: assert property (
    @(posedge clk) disable iff (!rst_b)
      wr_idle_s |=> $stable(word))
    else $error("word changed without write");

  // parity bit kept exactly as the host wrote it
  parity_kept_a: assert property (
    @(posedge clk) disable iff (!rst_b)
      wr_hit_s |=>
        word[gdr_pkg::PAR_BIT] == $past(req.wdata[gdr_pkg::PAR_BIT]))
    else $error("parity bit not kept");

  // reserved bit never stored
  reserved_zero_a: assert property (
    @(posedge clk) disable iff (!rst_b) word[gdr_pkg::RES_BIT] == 1'b0)
    else $error("reserved bit set");

  // read of this offset returns the word, reserved bit zero
  read_value_a: assert property (
    @(posedge clk) disable iff (!rst_b)
      hit(rd_addr) |->
        rd_data[gdr_pkg::RES_BIT] == 1'b0 && rd_data == word)
    else $error("read data wrong");

  // read of any other offset returns zero
  read_miss_a: assert property (
    @(posedge clk) disable iff (!rst_b)
      !hit(rd_addr) |-> !rd_hit && rd_data == 16'h0000)
    else $error("read miss not zero");

  // zero charge code selects the low-impedance switches
  charge_lowz_a: assert property (
    @(posedge clk) disable iff (!rst_b)
      rst_b && word[gdr_pkg::CHG_MSB:gdr_pkg::CHG_LSB] == 5'h0 |=>
        bridge_cfg.charge_lowz)
    else $error("charge low impedance missing");

  // zero discharge code selects the low-impedance switches
  discharge_lowz_a: assert property (
    @(posedge clk) disable iff (!rst_b)
      rst_b && word[gdr_pkg::DIS_MSB:gdr_pkg::DIS_LSB] == 5'h0 |=>
        bridge_cfg.discharge_lowz)
    else $error("discharge low impedance missing");

  // low-impedance flags agree with their codes in both directions
  lowz_match_a: assert property (
    @(posedge clk) disable iff (!rst_b)
      run_s |->
        bridge_cfg.charge_lowz ==
          (bridge_cfg.charge_current_code == 5'h0) &&
        bridge_cfg.discharge_lowz ==
          (bridge_cfg.discharge_current_code == 5'h0))
    else $error("low impedance flag disagrees with code");

  // dead-time count is (k+1) steps of the dead-time unit
  dead_time_a: assert property (
    @(posedge clk) disable iff (!rst_b)
      rst_b |=> bridge_cfg.dead_time_cycles ==
        9'((32'($past(word[gdr_pkg::DT_MSB:gdr_pkg::DT_LSB])) + 1) *
           gdr_pkg::DT_STEP_CYC))
    else $error("dead time count wrong");

  // dead time stays between one and sixteen steps
  dead_range_a: assert property (
    @(posedge clk) disable iff (!rst_b)
      run_s |->
        bridge_cfg.dead_time_cycles >= 9'(gdr_pkg::DT_STEP_CYC) &&
        bridge_cfg.dead_time_cycles <= 9'(gdr_pkg::DT_MAX_CYC))
    else $error("dead time out of range");

  // charge code follows the stored word one edge later
  charge_code_a: assert property (
    @(posedge clk) disable iff (!rst_b)
      rst_b |=> bridge_cfg.charge_current_code ==
        $past(word[gdr_pkg::CHG_MSB:gdr_pkg::CHG_LSB]))
    else $error("charge code wrong");

  // discharge code follows the stored word one edge later
  discharge_code_a: assert property (
    @(posedge clk) disable iff (!rst_b)
      rst_b |=> bridge_cfg.discharge_current_code ==
        $past(word[gdr_pkg::DIS_MSB:gdr_pkg::DIS_LSB]))
    else $error("discharge code wrong");

  // a write reaches the leg settings two edges after it is taken
  property wr_route_p;
    @(posedge clk) disable iff (!rst_b)
      wr_land_s |=>
        bridge_cfg.charge_current_code ==
          $past(req.wdata[gdr_pkg::CHG_MSB:gdr_pkg::CHG_LSB], 2) &&
        bridge_cfg.discharge_current_code ==
          $past(req.wdata[gdr_pkg::DIS_MSB:gdr_pkg::DIS_LSB], 2) &&
        bridge_cfg.dead_time_code ==
          $past(req.wdata[gdr_pkg::DT_MSB:gdr_pkg::DT_LSB], 2);
  endproperty
  wr_route_a: assert property (wr_route_p)
    else $error("written fields not routed");

  // mode 1 routes the settings to leg 1 only
  mode_route_a: assert property (
    @(posedge clk) disable iff (!rst_b)
      rst_b && $rose(input_mode_select) |=>
        leg_one_active && !bridge_active)
    else $error("mode routing wrong");

  // mode 0 routes the settings to the full bridge
  mode_fall_a: assert property (
    @(posedge clk) disable iff (!rst_b)
      rst_b && $fell(input_mode_select) |=>
        bridge_active && !leg_one_active)
    else $error("full bridge routing wrong");

  // exactly one destination follows the mode once out of reset
  mode_level_a: assert property (
    @(posedge clk) disable iff (!rst_b)
      run_s |=> bridge_active == !$past(input_mode_select) &&
        leg_one_active == $past(input_mode_select))
    else $error("routing flags disagree with mode");

endmodule

// ===== tb/gdr_host_model.sv
/*
  gdr_host_model: host side, issues register writes and read selects.
  assumes: one clock shared with the register block.
*/
`timescale 1ns/10ps
module gdr_host_model (
  input  wire logic          clk,
  output gdr_pkg::gdr_req_s  req,
  output logic [7:0]         rd_addr
);
  initial begin
    req = '0;
    rd_addr = 8'h04;
  end
  // one-cycle write strobe; parity over bits 15:1 in bit 0
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{1'b1, a, {d[15:1], ~^d[15:1]}};
    @(posedge clk);
    req <= '{1'b0, ~a, ~d}; // released lines show no stale value
  endtask
  task automatic sel(input logic [7:0] a);
    rd_addr <= a;
  endtask
endmodule

// ===== tb/testbench.sv
/*
  testbench: random and boundary writes, readback and decode checks.
  assumes: gdr_pkg compiled first; host model drives the request side.
*/
`timescale 1ns/10ps
module testbench;
  logic clk = 0, rst_b = 0, mode = 0, chk = 0, rd_hit, br, l1;
  gdr_pkg::gdr_req_s     req;
  gdr_pkg::gdr_leg_cfg_s cfg;
  logic [7:0]  rd_addr, scale;
  logic [15:0] rd_data, w, st;
  logic [51:0] q[$];
  logic [31:0] seed = 32'd42047;
  int fail_count = 0, compares = 0;
  always #5 clk = ~clk;
  gdr_host_model host_u (.clk(clk), .req(req), .rd_addr(rd_addr));
  gdr_timing_current_reg dut_u (.clk(clk), .rst_b(rst_b), .req(req),
    .rd_addr(rd_addr), .input_mode_select(mode), .rd_data(rd_data),
    .rd_hit(rd_hit), .bridge_cfg(cfg), .bridge_active(br),
    .leg_one_active(l1), .max_gate_scale(scale));
  wire [51:0] got = {rd_data, rd_hit, cfg, br, l1, scale};
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // expected port view of stored word v
  function automatic logic [51:0] ev(input logic [15:0] v, input logic h);
    logic [3:0] k;
    k = v[10:7];
    return {h ? v : 16'h0000, h, v[15:11], v[15:11] == 5'h00, v[5:1],
      v[5:1] == 5'h00, k, 9'((k + 1) * gdr_pkg::DT_STEP_CYC), ~mode,
      mode, 8'(gdr_pkg::CUR_FULL_SCALE)};
  endfunction
  task automatic cmp(input logic [51:0] e, input logic [51:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic note(input logic h);
    q.push_back(ev(st, h));
    chk <= 1;
    @(posedge clk);
    chk <= 0;
  endtask
  task automatic complete_run;
    $display("fail_count %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watcher takes the oldest note at each settled result
  always @(negedge clk) begin
    if (chk && q.size() == 0)
      cmp(52'h0, 52'h1);
    else if (chk)
      cmp(q.pop_front(), got);
  end
  initial begin
    st = 16'h0000;
    repeat (6) @(posedge clk);
    rst_b <= 1;
    repeat (2) @(posedge clk);
    note(1'b1);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      w = i == 0 ? 16'hFFFF : i == 1 ? 16'h0840 : i == 2 ? 16'h0000 :
        seed[15:0];
      mode <= seed[21];
      host_u.sel(seed[22] ? 8'h05 : 8'h04);
      host_u.wr(seed[20] && i > 2 ? 8'h05 : 8'h04, w);
      if (!(seed[20] && i > 2))
        st = {w[15:1], ~^w[15:1]} & gdr_pkg::GD1_TC_WMASK;
      repeat (2) @(posedge clk);
      note(!seed[22]);
    end
    // second reset in mid-run brings the word back to zero
    host_u.sel(8'h04);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    st = 16'h0000;
    repeat (2) @(posedge clk);
    note(1'b1);
    complete_run();
  end
endmodule
